// [src/as_parity.sv]
`timescale 1ns/1ps

module as_parity (
   // Format
   input  wire logic              seven_bit,
   input  wire as_pkg::as_parmode_e par_mode,
   // Receive check
   input  wire logic [7:0]        chk_word,
   input  wire logic              chk_par,
   output logic                   chk_err,
   // Transmit generation
   input  wire logic [7:0]        gen_word,
   output logic                   gen_bit
);

   logic [7:0] mask;
   logic       odd_sel;
   logic       par_on;

   assign mask    = seven_bit ? 8'h7f : 8'hff;
   assign odd_sel = (par_mode == as_pkg::AS_PAR_ODD);
   assign par_on  = (par_mode != as_pkg::AS_PAR_NONE);

   // Error when total ones disagree with the chosen sense
   assign chk_err = par_on & (^(chk_word & mask) ^ chk_par ^ odd_sel);
   // Generator gives a bit that makes the total match
   assign gen_bit = par_on & (^(gen_word & mask) ^ odd_sel);

endmodule

// [src/as_pkg.sv]
package as_pkg;

   typedef logic [7:0] as_byte_t;

   typedef enum logic [1:0] {
      AS_PAR_NONE,
      AS_PAR_EVEN,
      AS_PAR_ODD
   } as_parmode_e;

endpackage

// [src/as_status_flags.sv]
// Functional notes
// - Status bit 3 mirrors the clear-to-send input: low means clear.
// - Clear-to-send high keeps transmit-empty status from reading empty.
// - Master reset leaves the clear-to-send status bit following its input.
// - Frame fault bit 4 set when first stop bit of character missing.
// - Frame fault updated on load into holding, valid while held.
// - Overrun detected when second unread character completes its last bit.
// - Overrun shows in status only after the valid character is read.
// - Receive-full stays set while the overrun is uncleared.
// - Receiver framing keeps running through an overrun.
// - Overrun cleared by holding register read or master reset.
// - Parity fault bit 6 set when ones count disagrees with parity.
// - Parity fault stays while offending character remains held.
// - No-parity formats suppress transmit generator and receive check.
// - Status bit 7 high whenever interrupt output is asserted low.
// - Interrupt asserted for any source whose enable is set.
// - Holding register read or transmit write clears interrupt request.
// - Both divide bits high give master reset of status and link.
// - Status presented on read with bus select high, register select low and read/write high.
// - Control bit 7 enables receive-full, overrun, carrier-rise interrupts.
// - Receive-full cleared by holding register read or master reset.
`include "as_status_params.svh"
`timescale 1ns/1ps

module as_status_flags (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Processor bus
   input  wire logic       bus_sel,
   input  wire logic       bus_rs,
   input  wire logic       bus_rw,
   input  wire logic [7:0] bus_wdata,
   output logic      [7:0] bus_rdata,
   output logic            irq_n,
   // Modem pins
   input  wire logic       cts_n,
   input  wire logic       dcd_n,
   output logic            rts_n,
   // Receiver side
   input  wire logic       rx_done,
   input  wire logic [7:0] rx_word,
   input  wire logic       rx_par,
   input  wire logic       rx_stop_ok,
   // Transmitter side
   input  wire logic       tx_take,
   output logic [7:0]      tx_data,
   output logic            tx_par_bit,
   output logic            tx_ready,
   output logic            tx_break,
   // Shared control
   output logic            link_mreset,
   output logic            rx_inhibit,
   output logic [1:0]      clk_div_sel,
   output logic [2:0]      word_sel
);

   // Bus decode
   logic rd_rx;
   logic wr_tx;
   logic wr_ctl;
   logic rd_st;
   assign rd_rx  = bus_sel & bus_rs & bus_rw;
   assign wr_tx  = bus_sel & bus_rs & ~bus_rw;
   assign wr_ctl = bus_sel & ~bus_rs & ~bus_rw;
   assign rd_st  = bus_sel & ~bus_rs & bus_rw;

   // Modem input synchronisers
   logic [1:0] modem_s;
   logic       cts_s;
   logic       dcd_s;
   as_sync2 #(.WIDTH(2)) u_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in ({dcd_n, cts_n}),
      .sync_out (modem_s)
   );
   assign cts_s = modem_s[0];
   assign dcd_s = modem_s[1];

   // Control register
   logic [7:0] ctl_q;
   logic [7:0] ctl_d;
   logic       mr;
   logic       seven_bit;
   logic       rx_ie;
   logic       tx_ie;
   logic [1:0] tx_ctl;
   as_pkg::as_parmode_e par_mode;

   always_comb begin
      ctl_d = ctl_q;
      if (wr_ctl) begin
         ctl_d = bus_wdata;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctl_q <= `AS_CTL_RST;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   assign mr = (ctl_q[`AS_CT_DIV_HI:`AS_CT_DIV_LO] == `AS_DIV_MRESET);
   assign word_sel    = ctl_q[`AS_CT_WS_HI:`AS_CT_WS_LO];
   assign clk_div_sel = ctl_q[`AS_CT_DIV_HI:`AS_CT_DIV_LO];
   assign tx_ctl      = ctl_q[`AS_CT_TX_HI:`AS_CT_TX_LO];
   assign rx_ie       = ctl_q[`AS_CT_RXIE];
   assign tx_ie       = (tx_ctl == `AS_TX_IRQ_ON);
   assign seven_bit   = ~word_sel[2];
   assign rts_n       = (tx_ctl == `AS_TX_RTS_OFF);
   assign tx_break    = (tx_ctl == `AS_TX_BREAK);
   assign link_mreset = mr;
   assign rx_inhibit  = dcd_s;

   always_comb begin
      if (word_sel[2] & ~word_sel[1]) begin
         par_mode = as_pkg::AS_PAR_NONE;
      end else if (word_sel[0]) begin
         par_mode = as_pkg::AS_PAR_ODD;
      end else begin
         par_mode = as_pkg::AS_PAR_EVEN;
      end
   end

   // Parity check and generation
   logic chk_err;
   as_parity u_par (
      .seven_bit (seven_bit),
      .par_mode  (par_mode),
      .chk_word  (rx_word),
      .chk_par   (rx_par),
      .chk_err   (chk_err),
      .gen_word  (tx_data),
      .gen_bit   (tx_par_bit)
   );

   // Receive holding register and its flags
   as_pkg::as_byte_t rx_hold_q;
   as_pkg::as_byte_t rx_hold_d;
   logic rx_full_q;
   logic rx_full_d;
   logic frame_q;
   logic frame_d;
   logic par_q;
   logic par_d;
   logic lost_q;
   logic lost_d;
   logic pend_q;
   logic pend_d;
   logic rx_ok;
   assign rx_ok = rx_done & ~mr & ~dcd_s;
   always_comb begin
      rx_hold_d = rx_hold_q;
      rx_full_d = rx_full_q;
      frame_d   = frame_q;
      par_d     = par_q;
      lost_d    = lost_q;
      pend_d    = pend_q;
      if (rd_rx) begin
         if (pend_q) begin
            lost_d = 1'b1;
            pend_d = 1'b0;
         end else begin
            rx_full_d = 1'b0;
            lost_d    = 1'b0;
         end
      end
      if (rx_ok) begin
         if (!rx_full_d) begin
            rx_hold_d = seven_bit ? {1'b0, rx_word[6:0]} : rx_word;
            rx_full_d = 1'b1;
            frame_d   = ~rx_stop_ok;
            par_d     = chk_err;
         end else begin
            pend_d = 1'b1;
         end
      end
      if (mr) begin
         rx_full_d = 1'b0;
         frame_d   = 1'b0;
         par_d     = 1'b0;
         lost_d    = 1'b0;
         pend_d    = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_hold_q <= `AS_BYTE_RST;
         rx_full_q <= 1'b0;
         frame_q   <= 1'b0;
         par_q     <= 1'b0;
         lost_q    <= 1'b0;
         pend_q    <= 1'b0;
      end else begin
         rx_hold_q <= rx_hold_d;
         rx_full_q <= rx_full_d;
         frame_q   <= frame_d;
         par_q     <= par_d;
         lost_q    <= lost_d;
         pend_q    <= pend_d;
      end
   end

   // Carrier loss latch
   logic dcd_prev_q;
   logic carrier_q;
   logic carrier_d;
   logic armed_q;
   logic armed_d;

   always_comb begin
      carrier_d = carrier_q;
      armed_d   = armed_q;
      if (rd_st & carrier_q) begin
         armed_d = 1'b1;
      end
      if (rd_rx & armed_q) begin
         carrier_d = 1'b0;
         armed_d   = 1'b0;
      end
      if (mr) begin
         carrier_d = 1'b0;
         armed_d   = 1'b0;
      end
      if (dcd_s & ~dcd_prev_q) begin
         carrier_d = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dcd_prev_q <= 1'b1;
         carrier_q  <= 1'b0;
         armed_q    <= 1'b0;
      end else begin
         dcd_prev_q <= dcd_s;
         carrier_q  <= carrier_d;
         armed_q    <= armed_d;
      end
   end

   // Transmit holding register
   as_pkg::as_byte_t tx_hold_q;
   as_pkg::as_byte_t tx_hold_d;
   logic tx_empty_q;
   logic tx_empty_d;

   always_comb begin
      tx_hold_d  = tx_hold_q;
      tx_empty_d = tx_empty_q;
      if (tx_take) begin
         tx_empty_d = 1'b1;
      end
      if (wr_tx) begin
         tx_hold_d  = bus_wdata;
         tx_empty_d = 1'b0;
      end
      if (mr) begin
         tx_empty_d = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_hold_q  <= `AS_BYTE_RST;
         tx_empty_q <= 1'b1;
      end else begin
         tx_hold_q  <= tx_hold_d;
         tx_empty_q <= tx_empty_d;
      end
   end

   assign tx_data  = tx_hold_q;
   assign tx_ready = ~tx_empty_q & ~mr;

   // Interrupt and status assembly
   logic [7:0] st;
   logic       rx_full_vis;
   logic       tx_empty_vis;
   logic       irq_d;
   logic       irq_n_q;

   assign rx_full_vis  = rx_full_q & ~dcd_s;
   assign tx_empty_vis = tx_empty_q & ~cts_s;
   assign irq_d = (rx_ie & (rx_full_vis | lost_q | carrier_q))
                | (tx_ie & tx_empty_vis);

   always_comb begin
      st                = 8'h00;
      st[`AS_ST_RXFULL] = rx_full_vis;
      st[`AS_ST_TXEMPTY]= tx_empty_vis;
      st[`AS_ST_CARRIER]= carrier_q | dcd_s;
      st[`AS_ST_CTS]    = cts_s;
      st[`AS_ST_FRAME]  = frame_q;
      st[`AS_ST_LOST]   = lost_q;
      st[`AS_ST_PARITY] = par_q;
      st[`AS_ST_IRQ]    = ~irq_n_q;
   end

   // Bus read data
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   always_comb begin
      rdata_d = rdata_q;
      if (rd_st) begin
         rdata_d = st;
      end else if (rd_rx) begin
         rdata_d = rx_hold_q;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_q <= `AS_BYTE_RST;
         irq_n_q <= 1'b1;
      end else begin
         rdata_q <= rdata_d;
         irq_n_q <= ~irq_d;
      end
   end

   assign bus_rdata = rdata_q;
   assign irq_n     = irq_n_q;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_cts_mirror: assert property (
      rd_st |=> bus_rdata[`AS_ST_CTS] == $past(cts_s))
      else $error("status bit 3 does not follow clear-to-send");
   chk_tx_inhibit: assert property (
      rd_st && cts_s |=> !bus_rdata[`AS_ST_TXEMPTY])
      else $error("transmit empty shown while clear-to-send high");
   chk_cts_mreset: assert property (
      mr && rd_st |=> bus_rdata[`AS_ST_CTS] == $past(cts_s))
      else $error("master reset disturbed clear-to-send status");
   chk_frame_load: assert property (
      rx_ok && !rx_full_q && !rd_rx && !mr
      |=> frame_q == !$past(rx_stop_ok) && rx_full_q)
      else $error("frame fault not loaded with character");
   chk_frame_hold: assert property (
      rx_full_q && !rd_rx && !mr |=> $stable(frame_q) && $stable(par_q))
      else $error("error flags changed while character held");
   chk_lost_pend: assert property (
      rx_ok && rx_full_q && !rd_rx |=> pend_q)
      else $error("overrun not detected");
   chk_lost_late: assert property (
      $rose(lost_q) |-> $past(rd_rx) && $past(pend_q))
      else $error("overrun shown before valid character read");
   chk_full_hold: assert property (lost_q |-> rx_full_q)
      else $error("receive full dropped during overrun");
   chk_lost_clear: assert property (
      lost_q && rd_rx && !pend_q |=> !lost_q)
      else $error("overrun not cleared by data read");
   chk_par_none: assert property (
      par_mode == as_pkg::AS_PAR_NONE |-> !tx_par_bit && !chk_err)
      else $error("parity active with no-parity format");
   chk_irq_level: assert property (
      irq_d |=> !irq_n ##0 st[`AS_ST_IRQ])
      else $error("interrupt output or status bit 7 wrong");
   chk_mreset_flags: assert property (
      mr |=> !rx_full_q && !lost_q && !frame_q && tx_empty_q)
      else $error("master reset did not clear status");
   chk_full_clear: assert property (
      rd_rx && !pend_q && !rx_ok |=> !rx_full_q)
      else $error("receive full not cleared by read");

endmodule

// [src/as_status_params.svh]
`ifndef AS_STATUS_PARAMS_SVH
`define AS_STATUS_PARAMS_SVH

// Status byte field positions
`define AS_ST_RXFULL   0
`define AS_ST_TXEMPTY  1
`define AS_ST_CARRIER  2
`define AS_ST_CTS      3
`define AS_ST_FRAME    4
`define AS_ST_LOST     5
`define AS_ST_PARITY   6
`define AS_ST_IRQ      7

// Control byte field positions
`define AS_CT_DIV_LO   0
`define AS_CT_DIV_HI   1
`define AS_CT_WS_LO    2
`define AS_CT_WS_HI    4
`define AS_CT_TX_LO    5
`define AS_CT_TX_HI    6
`define AS_CT_RXIE     7

// Control codes
`define AS_DIV_MRESET  2'h3
`define AS_TX_IRQ_ON   2'h1
`define AS_TX_RTS_OFF  2'h2
`define AS_TX_BREAK    2'h3

// Reset values
`define AS_CTL_RST     8'h03
`define AS_BYTE_RST    8'h00

`endif

// [src/as_sync2.sv]
`timescale 1ns/1ps

module as_sync2 #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // Idle modem lines are high
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

// [test/as_cpu_model.sv]
`timescale 1ns/1ps

module as_cpu_model (
   // Clock
   input  wire logic             clk,
   // Bus to the adapter
   output logic                  bus_sel,
   output logic                  bus_rs,
   output logic                  bus_rw,
   output as_pkg::as_byte_t      bus_wdata,
   input  wire as_pkg::as_byte_t bus_rdata
);
   initial begin
      bus_sel   = 1'b0;
      bus_rs    = 1'b0;
      bus_rw    = 1'b1;
      bus_wdata = 8'h00;
   end

   // One strobe cycle, then data lines show the inverse
   task automatic acc(input logic rs, input logic rw,
                      input as_pkg::as_byte_t d);
      @(posedge clk);
      bus_sel   <= 1'b1;
      bus_rs    <= rs;
      bus_rw    <= rw;
      bus_wdata <= d;
      @(posedge clk);
      bus_sel   <= 1'b0;
      bus_wdata <= ~d;
   endtask

   task automatic wr(input logic rs, input as_pkg::as_byte_t d);
      acc(rs, 1'b0, d);
   endtask

   // Read data lands on the taking edge and is sampled one cycle later
   task automatic rd(input logic rs, output as_pkg::as_byte_t q);
      acc(rs, 1'b1, 8'h00);
      @(posedge clk);
      #1;
      q = bus_rdata;
   endtask

   task automatic mrst();
      wr(1'b0, 8'h03);
   endtask
endmodule

// [test/as_status_flags_bench.sv]
`timescale 1ns/1ps

module as_status_flags_bench;
   typedef struct packed {
      as_pkg::as_byte_t ctl;
      as_pkg::as_byte_t wrd;
      logic             par;
      logic             stp;
      as_pkg::as_byte_t st;
      as_pkg::as_byte_t dat;
   } as_row_s;

   logic             clk        = 1'b0;
   logic             sys_rst    = 1'b1;
   logic             cts_n      = 1'b0;
   logic             dcd_n      = 1'b0;
   logic             rx_done    = 1'b0;
   as_pkg::as_byte_t rx_word    = 8'h00;
   logic             rx_par     = 1'b0;
   logic             rx_stop_ok = 1'b1;
   logic             tx_take    = 1'b0;
   logic             bus_sel;
   logic             bus_rs;
   logic             bus_rw;
   as_pkg::as_byte_t bus_wdata;
   as_pkg::as_byte_t bus_rdata;
   as_pkg::as_byte_t tx_data;
   as_pkg::as_byte_t q;
   logic             irq_n;
   logic             rts_n;
   logic             tx_par_bit;
   logic             tx_ready;
   logic             tx_break;
   logic             link_mreset;
   logic             rx_inhibit;
   logic [1:0]       clk_div_sel;
   logic [2:0]       word_sel;
   int               errors     = 0;
   int               checks     = 0;

   // One row per word format
   as_row_s rows [8] = '{
      '{8'h00, 8'h81, 1'b1, 1'b1, 8'h03, 8'h01},
      '{8'h04, 8'h01, 1'b1, 1'b0, 8'h53, 8'h01},
      '{8'h08, 8'h7f, 1'b0, 1'b1, 8'h43, 8'h7f},
      '{8'h0c, 8'h7f, 1'b0, 1'b1, 8'h03, 8'h7f},
      '{8'h90, 8'hff, 1'b0, 1'b1, 8'h83, 8'hff},
      '{8'h14, 8'h00, 1'b1, 1'b1, 8'h03, 8'h00},
      '{8'h18, 8'h07, 1'b0, 1'b1, 8'h43, 8'h07},
      '{8'h9c, 8'h07, 1'b0, 1'b0, 8'h93, 8'h07}
   };

   always #12.5 clk = ~clk;

   as_status_flags as_status_flags_i (
      .clk(clk), .sys_rst(sys_rst), .bus_sel(bus_sel), .bus_rs(bus_rs),
      .bus_rw(bus_rw), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .irq_n(irq_n), .cts_n(cts_n), .dcd_n(dcd_n), .rts_n(rts_n),
      .rx_done(rx_done), .rx_word(rx_word), .rx_par(rx_par),
      .rx_stop_ok(rx_stop_ok), .tx_take(tx_take), .tx_data(tx_data),
      .tx_par_bit(tx_par_bit), .tx_ready(tx_ready), .tx_break(tx_break),
      .link_mreset(link_mreset), .rx_inhibit(rx_inhibit),
      .clk_div_sel(clk_div_sel), .word_sel(word_sel)
   );

   as_cpu_model as_cpu_model_i (
      .clk(clk), .bus_sel(bus_sel), .bus_rs(bus_rs), .bus_rw(bus_rw),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata)
   );

   task automatic chk(input string nm, input as_pkg::as_byte_t e,
                      input as_pkg::as_byte_t g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic sts(input as_pkg::as_byte_t e, input as_pkg::as_byte_t m);
      as_cpu_model_i.rd(1'b0, q);
      chk("status", e, q & m);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Receiver pulse; data lines show the inverse afterwards
   task automatic rxc(input as_pkg::as_byte_t w, input logic p,
                      input logic s);
      @(posedge clk);
      rx_done    <= 1'b1;
      rx_word    <= w;
      rx_par     <= p;
      rx_stop_ok <= s;
      @(posedge clk);
      rx_done    <= 1'b0;
      rx_word    <= ~w;
      rx_par     <= ~p;
      rx_stop_ok <= ~s;
      wt(2);
   endtask

   task automatic end_of_test();
      $display("Checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      end_of_test();
   end

   initial begin
      wt(3);
      chk("reset rdata", 8'h00, bus_rdata);
      chk("reset irq", 8'h01, {7'h00, irq_n});
      chk("reset mreset", 8'h01, {7'h00, link_mreset});
      @(posedge clk) sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         as_cpu_model_i.mrst();
         as_cpu_model_i.wr(1'b0, rows[i].ctl);
         rxc(rows[i].wrd, rows[i].par, rows[i].stp);
         sts(rows[i].st, 8'hff);
         as_cpu_model_i.rd(1'b1, q);
         chk("rx data", rows[i].dat, q);
         sts(rows[i].st & 8'h5e, 8'hff);
      end
      @(posedge clk) cts_n <= 1'b1;
      wt(3);
      sts(8'h08, 8'h0a);
      as_cpu_model_i.mrst();
      sts(8'h08, 8'h0a);
      as_cpu_model_i.wr(1'b0, 8'h00);
      sts(8'h08, 8'h0a);
      @(posedge clk) cts_n <= 1'b0;
      wt(3);
      sts(8'h02, 8'h0a);
      as_cpu_model_i.wr(1'b0, 8'h80);
      rxc(8'h01, 1'b1, 1'b1);
      rxc(8'h02, 1'b0, 1'b1);
      sts(8'h81, 8'ha1);
      as_cpu_model_i.rd(1'b1, q);
      chk("rx kept", 8'h01, q);
      sts(8'h21, 8'h21);
      as_cpu_model_i.rd(1'b1, q);
      sts(8'h00, 8'h21);
      rxc(8'h03, 1'b0, 1'b1);
      as_cpu_model_i.rd(1'b1, q);
      chk("rx after lost", 8'h03, q);
      rxc(8'h01, 1'b1, 1'b1);
      rxc(8'h02, 1'b0, 1'b1);
      as_cpu_model_i.rd(1'b1, q);
      as_cpu_model_i.mrst();
      as_cpu_model_i.wr(1'b0, 8'h80);
      sts(8'h00, 8'h21);
      @(posedge clk) dcd_n <= 1'b1;
      wt(3);
      chk("rx inhibit", 8'h01, {7'h00, rx_inhibit});
      sts(8'h84, 8'h85);
      @(posedge clk) dcd_n <= 1'b0;
      wt(3);
      chk("rx enable", 8'h00, {7'h00, rx_inhibit});
      as_cpu_model_i.rd(1'b0, q);
      as_cpu_model_i.rd(1'b1, q);
      sts(8'h00, 8'h84);
      as_cpu_model_i.mrst();
      as_cpu_model_i.wr(1'b0, 8'h20);
      sts(8'h82, 8'h82);
      chk("irq low", 8'h00, {7'h00, irq_n});
      as_cpu_model_i.wr(1'b1, 8'h5b);
      wt(2);
      chk("tx data", 8'h5b, tx_data);
      chk("tx ready", 8'h01, {7'h00, tx_ready});
      chk("tx par", 8'h01, {7'h00, tx_par_bit});
      sts(8'h00, 8'h82);
      @(posedge clk) tx_take <= 1'b1;
      @(posedge clk) tx_take <= 1'b0;
      wt(2);
      sts(8'h82, 8'h82);
      as_cpu_model_i.wr(1'b0, 8'h30);
      wt(2);
      chk("tx par none", 8'h00, {7'h00, tx_par_bit});
      chk("word sel", 8'h04, {5'h00, word_sel});
      chk("div sel", 8'h00, {6'h00, clk_div_sel});
      chk("rts on", 8'h00, {7'h00, rts_n});
      chk("break idle", 8'h00, {7'h00, tx_break});
      chk("irq tx", 8'h00, {7'h00, irq_n});
      @(posedge clk) sys_rst <= 1'b1;
      wt(2);
      chk("mid rdata", 8'h00, bus_rdata);
      chk("mid irq", 8'h01, {7'h00, irq_n});
      chk("mid mreset", 8'h01, {7'h00, link_mreset});
      chk("mid tx data", 8'h00, tx_data);
      @(posedge clk) sys_rst <= 1'b0;
      as_cpu_model_i.wr(1'b0, 8'h40);
      wt(2);
      chk("rts off", 8'h01, {7'h00, rts_n});
      as_cpu_model_i.wr(1'b0, 8'h60);
      wt(2);
      chk("break", 8'h01, {7'h00, tx_break});
      chk("rts break", 8'h00, {7'h00, rts_n});
      sts(8'h02, 8'hff);
      end_of_test();
   end
endmodule
